// >>> tfr_pkg.sv
// Overview of operation
// - Embedded marker is forced off whenever turbo coding is configured.
// - Software selects embedded marker for recorded streams meant for forward insertion.
// - Embedded marker is 32-bit 352EF853, bit 0 sent first.
// - Randomize enable is frozen while the channel runs.
// - Randomize setting is never signalled in-band; both ends are preset alike.
// - Every frame bit is XORed with the matching generator bit.
// - Transmit randomizing sits after block encoding, before convolutional encoding.
// - Receive derandomizing sits after convolutional decoding and sync, before decoding.
// - Turbo soft symbols are inverted where the sequence bit is one.
// - Transmit sequence first bit meets the first frame bit.
// - Receive sequence starts on the bit right after the detected marker.
// - Marker bits bypass the XOR and the generator holds still.
// - Transmitter and receiver use one identical generator function.
// - Generator is polynomial x^8+x^7+x^5+x^3+1 in eight stages.
// - Free-running generator repeats every 255 bits.
// - Generator is preset to all ones at each frame start.
// - One generator step per data bit, first to last frame bit.
// - First 40 output bits are FF 48 0E C0 9A.
// - Standard non-turbo marker is 1ACFFC1D.
// - Turbo markers are 64 bits at rate half, 128 at quarter.
// - Each marker directly follows the previous frame, no fill between.
`default_nettype none
package tfr_pkg;
   // --------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------
   localparam logic [7:0] TFR_REG_CTRL = 8'h00;
   localparam logic [7:0] TFR_REG_FLEN = 8'h04;
   localparam logic [7:0] TFR_REG_STAT = 8'h08;

   localparam int TFR_CTRL_RUN = 0;
   localparam int TFR_CTRL_RAND = 1;
   localparam int TFR_CTRL_EMB = 2;
   localparam int TFR_CTRL_TURBO_LO = 4;
   localparam int TFR_CTRL_TURBO_HI = 5;

   localparam int TFR_STAT_TX_BUSY = 0;
   localparam int TFR_STAT_RX_FRAME = 1;
   localparam int TFR_STAT_TXCNT_LO = 8;
   localparam int TFR_STAT_TXCNT_HI = 15;
   localparam int TFR_STAT_RXCNT_LO = 16;
   localparam int TFR_STAT_RXCNT_HI = 23;

   localparam int TFR_FLEN_W = 16;
   localparam logic [TFR_FLEN_W-1:0] TFR_FLEN_RST = 16'h2000;

   // --------------------------------------------------------------
   // Coding modes and markers
   // --------------------------------------------------------------
   localparam logic [1:0] TFR_TURBO_NONE = 2'h0;
   localparam logic [1:0] TFR_TURBO_HALF = 2'h1;
   localparam logic [1:0] TFR_TURBO_QUARTER = 2'h2;

   localparam int TFR_MK_W = 128;
   localparam int TFR_MK_IDX_W = 7;
   // Markers are left-justified; the MSB goes out first
   localparam logic [TFR_MK_W-1:0] TFR_MK_STD =
      {32'h1acffc1d, 96'h0};
   localparam logic [TFR_MK_W-1:0] TFR_MK_EMB =
      {32'h352ef853, 96'h0};
   localparam logic [TFR_MK_W-1:0] TFR_MK_TURBO =
      {64'h034776c7272895b0, 64'hfcb88938d8d76a4f};
   localparam logic [TFR_MK_IDX_W-1:0] TFR_MK_LAST_32 = 7'h1f;
   localparam logic [TFR_MK_IDX_W-1:0] TFR_MK_LAST_64 = 7'h3f;
   localparam logic [TFR_MK_IDX_W-1:0] TFR_MK_LAST_128 = 7'h7f;

   // --------------------------------------------------------------
   // Sequence generator
   // --------------------------------------------------------------
   localparam int TFR_LFSR_W = 8;
   localparam logic [TFR_LFSR_W-1:0] TFR_LFSR_SEED = 8'hff;
   localparam int TFR_TAP_A = 0;
   localparam int TFR_TAP_B = 3;
   localparam int TFR_TAP_C = 5;
   localparam int TFR_TAP_D = 7;

   // Shared by both directions so the sequences cannot drift apart
   function automatic logic [TFR_LFSR_W-1:0] tfr_lfsr_step(
      input logic [TFR_LFSR_W-1:0] s);
      logic fb;
      fb = s[TFR_TAP_A] ^ s[TFR_TAP_B] ^ s[TFR_TAP_C] ^ s[TFR_TAP_D];
      return {fb, s[TFR_LFSR_W-1:1]};
   endfunction

   typedef enum logic [2:0] {
      TFR_TX_IDLE = 3'b001,
      TFR_TX_MARK = 3'b010,
      TFR_TX_DATA = 3'b100
   } tfr_tx_state_t;
endpackage
`default_nettype wire

// >>> tfr_top.sv
// Design decisions made here: the Wishbone register port and the placing of the registers.
`default_nettype none
module tfr_top
   import tfr_pkg::*;
#(
   parameter int SYM_W = 4,
   parameter int CNT_W = 8
)(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Transmit frame bits from block encoder
   input wire logic tx_bit_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   // Transmit line toward convolutional encoder
   output logic line_bit_o,
   output logic line_valid_o,
   output logic line_marker_o,
   input wire logic line_ready_i,
   // Receive symbols from synchronizer
   input wire logic [SYM_W-1:0] rx_sym_i,
   input wire logic rx_valid_i,
   input wire logic rx_marker_found_i,
   // Receive symbols toward block decoder
   output logic [SYM_W-1:0] rx_sym_o,
   output logic rx_valid_o,
   output logic rx_in_frame_o
);

   // --------------------------------------------------------------
   // Configuration registers
   // --------------------------------------------------------------
   logic run;
   logic rand_en;
   logic emb_sel;
   logic [1:0] turbo;
   logic [TFR_FLEN_W-1:0] frame_len;
   logic wr_cfg;
   logic [1:0] wr_turbo;
   logic [TFR_FLEN_W-1:0] frame_last;

   assign wr_cfg = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign wr_turbo = wb_dat_i[TFR_CTRL_TURBO_HI:TFR_CTRL_TURBO_LO];
   assign frame_last = frame_len - 16'h0001;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         run <= 1'b0;
      end
      else if (wr_cfg && wb_adr_i == TFR_REG_CTRL && wb_sel_i[0])
      begin
         run <= wb_dat_i[TFR_CTRL_RUN];
      end
   end

   // Mode is only changed with the channel stopped
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rand_en <= 1'b0;
         emb_sel <= 1'b0;
         turbo <= TFR_TURBO_NONE;
      end
      else if (wr_cfg && wb_adr_i == TFR_REG_CTRL && wb_sel_i[0] && !run)
      begin
         rand_en <= wb_dat_i[TFR_CTRL_RAND];
         // Embedded marker is for recorded non-turbo streams
         emb_sel <= wb_dat_i[TFR_CTRL_EMB] &&
            wr_turbo == TFR_TURBO_NONE;
         turbo <= (wr_turbo == TFR_TURBO_HALF ||
            wr_turbo == TFR_TURBO_QUARTER) ? wr_turbo : TFR_TURBO_NONE;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         frame_len <= TFR_FLEN_RST;
      end
      else if (wr_cfg && wb_adr_i == TFR_REG_FLEN && !run)
      begin
         if (wb_sel_i[0])
         begin
            frame_len[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1])
         begin
            frame_len[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // --------------------------------------------------------------
   // Bus answer
   // --------------------------------------------------------------
   logic tx_busy;
   logic rx_in_frame;
   logic [CNT_W-1:0] tx_frames;
   logic [CNT_W-1:0] rx_frames;
   logic [31:0] next_rdata;

   always_comb
   begin
      next_rdata = 32'h0;
      unique case (wb_adr_i)
         TFR_REG_CTRL:
         begin
            next_rdata[TFR_CTRL_RUN] = run;
            next_rdata[TFR_CTRL_RAND] = rand_en;
            next_rdata[TFR_CTRL_EMB] = emb_sel;
            next_rdata[TFR_CTRL_TURBO_HI:TFR_CTRL_TURBO_LO] = turbo;
         end
         TFR_REG_FLEN:
         begin
            next_rdata[TFR_FLEN_W-1:0] = frame_len;
         end
         TFR_REG_STAT:
         begin
            next_rdata[TFR_STAT_TX_BUSY] = tx_busy;
            next_rdata[TFR_STAT_RX_FRAME] = rx_in_frame;
            next_rdata[TFR_STAT_TXCNT_HI:TFR_STAT_TXCNT_LO] = tx_frames;
            next_rdata[TFR_STAT_RXCNT_HI:TFR_STAT_RXCNT_LO] = rx_frames;
         end
         default:
         begin
            next_rdata = 32'h0;
         end
      endcase
   end

   // One wait state; unmapped addresses read zero and ignore writes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= next_rdata;
      end
   end

   // --------------------------------------------------------------
   // Transmit marker selection
   // --------------------------------------------------------------
   logic [TFR_MK_W-1:0] tx_marker;
   logic [TFR_MK_IDX_W-1:0] mk_last;

   always_comb
   begin
      if (turbo == TFR_TURBO_HALF)
      begin
         tx_marker = TFR_MK_TURBO;
         mk_last = TFR_MK_LAST_64;
      end
      else if (turbo == TFR_TURBO_QUARTER)
      begin
         tx_marker = TFR_MK_TURBO;
         mk_last = TFR_MK_LAST_128;
      end
      else if (emb_sel)
      begin
         tx_marker = TFR_MK_EMB;
         mk_last = TFR_MK_LAST_32;
      end
      else
      begin
         tx_marker = TFR_MK_STD;
         mk_last = TFR_MK_LAST_32;
      end
   end

   // --------------------------------------------------------------
   // Transmit sequencer
   // --------------------------------------------------------------
   tfr_tx_state_t tx_state;
   logic [TFR_MK_IDX_W-1:0] mk_idx;
   logic [TFR_FLEN_W-1:0] tx_cnt;
   logic [TFR_LFSR_W-1:0] tx_lfsr;
   logic out_free;
   logic tx_take;
   logic mk_emit;
   logic tx_frame_end;

   assign out_free = !line_valid_o || line_ready_i;
   assign tx_ready_o = tx_state == TFR_TX_DATA && out_free;
   assign tx_take = tx_ready_o && tx_valid_i;
   assign mk_emit = tx_state == TFR_TX_MARK && out_free;
   assign tx_frame_end = tx_take && tx_cnt == frame_last;
   assign tx_busy = tx_state != TFR_TX_IDLE;

   // A stop request lets the current frame finish
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_state <= TFR_TX_IDLE;
         mk_idx <= '0;
         tx_cnt <= '0;
      end
      else
      begin
         unique case (tx_state)
            TFR_TX_IDLE:
            begin
               mk_idx <= '0;
               if (run)
               begin
                  tx_state <= TFR_TX_MARK;
               end
            end
            TFR_TX_MARK:
            begin
               if (mk_emit)
               begin
                  mk_idx <= mk_idx + 7'h01;
                  if (mk_idx == mk_last)
                  begin
                     tx_state <= TFR_TX_DATA;
                     tx_cnt <= '0;
                  end
               end
            end
            TFR_TX_DATA:
            begin
               if (tx_take)
               begin
                  tx_cnt <= tx_cnt + 16'h0001;
               end
               if (tx_frame_end)
               begin
                  mk_idx <= '0;
                  // Next marker follows at once, no fill
                  tx_state <= run ? TFR_TX_MARK : TFR_TX_IDLE;
               end
            end
            default:
            begin
               tx_state <= TFR_TX_IDLE;
            end
         endcase
      end
   end

   // Generator holds at the seed over the whole marker
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_lfsr <= TFR_LFSR_SEED;
      end
      else if (tx_state != TFR_TX_DATA || tx_frame_end)
      begin
         tx_lfsr <= TFR_LFSR_SEED;
      end
      else if (tx_take)
      begin
         tx_lfsr <= tfr_lfsr_step(tx_lfsr);
      end
   end

   // Output stage carries block-encoded bits onward to the inner coder
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         line_valid_o <= 1'b0;
         line_bit_o <= 1'b0;
         line_marker_o <= 1'b0;
      end
      else if (mk_emit)
      begin
         line_valid_o <= 1'b1;
         line_bit_o <= tx_marker[TFR_MK_W - 1 - int'(mk_idx)];
         line_marker_o <= 1'b1;
      end
      else if (tx_take)
      begin
         line_valid_o <= 1'b1;
         line_bit_o <= tx_bit_i ^
            (rand_en & tx_lfsr[TFR_TAP_A]);
         line_marker_o <= 1'b0;
      end
      else if (line_ready_i)
      begin
         line_valid_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_frames <= '0;
      end
      else if (tx_frame_end)
      begin
         tx_frames <= tx_frames + 8'h01;
      end
   end

   // --------------------------------------------------------------
   // Receive derandomizer
   // --------------------------------------------------------------
   logic [TFR_FLEN_W-1:0] rx_cnt;
   logic [TFR_LFSR_W-1:0] rx_lfsr;
   logic rx_data;
   logic rx_sync;
   logic rx_frame_end;
   logic rx_flip;

   // Marker-found marks the last marker bit, never a data bit
   assign rx_sync = run && rx_valid_i && rx_marker_found_i;
   assign rx_data = rx_valid_i && rx_in_frame && !rx_marker_found_i;
   assign rx_frame_end = rx_data && rx_cnt == frame_last;
   assign rx_flip = rand_en && rx_lfsr[TFR_TAP_A];

   // A fresh marker resynchronises even mid-frame
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_in_frame <= 1'b0;
         rx_cnt <= '0;
         rx_lfsr <= TFR_LFSR_SEED;
      end
      else if (rx_sync)
      begin
         rx_in_frame <= 1'b1;
         rx_cnt <= '0;
         rx_lfsr <= TFR_LFSR_SEED;
      end
      else if (rx_data)
      begin
         rx_cnt <= rx_cnt + 16'h0001;
         rx_lfsr <= tfr_lfsr_step(rx_lfsr);
         if (rx_frame_end)
         begin
            rx_in_frame <= 1'b0;
         end
      end
   end

   // Soft symbols invert, so one-bit hard data reduces to XOR
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_valid_o <= 1'b0;
         rx_sym_o <= '0;
         rx_in_frame_o <= 1'b0;
      end
      else
      begin
         rx_valid_o <= rx_valid_i;
         rx_in_frame_o <= rx_data;
         if (rx_data && rx_flip)
         begin
            rx_sym_o <= ~rx_sym_i;
         end
         else
         begin
            rx_sym_o <= rx_sym_i;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_frames <= '0;
      end
      else if (rx_frame_end)
      begin
         rx_frames <= rx_frames + 8'h01;
      end
   end

endmodule
`default_nettype wire

// >>> tfr_top_chk.sv
`default_nettype none
module tfr_top_chk #(
   parameter int SYM_W = 4
)(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Transmit path
   input wire logic tx_valid_i,
   input wire logic tx_ready_o,
   input wire logic line_bit_o,
   input wire logic line_valid_o,
   input wire logic line_marker_o,
   input wire logic line_ready_i,
   // Receive path
   input wire logic [SYM_W-1:0] rx_sym_i,
   input wire logic rx_valid_i,
   input wire logic rx_marker_found_i,
   input wire logic [SYM_W-1:0] rx_sym_o,
   input wire logic rx_valid_o,
   input wire logic rx_in_frame_o
);
   logic [7:0] mk_run;
   logic acc;

   assign acc = line_valid_o && line_ready_i;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Length of the marker run just accepted downstream
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mk_run <= 8'h0;
      else if (acc)
         mk_run <= line_marker_o ? mk_run + 8'h1 : 8'h0;
   end

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_line_hold: assert property (line_valid_o && !line_ready_i |=>
      line_valid_o && $stable(line_bit_o) && $stable(line_marker_o))
      else $error("line output changed during stall");
   a_take_data: assert property (tx_valid_i && tx_ready_o |=>
      line_valid_o && !line_marker_o)
      else $error("taken data bit not shown as data");
   a_ready_gate: assert property (
      tx_ready_o |-> !line_valid_o || line_ready_i)
      else $error("ready while output stalled");
   a_marker_len: assert property (
      acc && !line_marker_o && mk_run != 8'h0 |->
      mk_run == 8'h20 || mk_run == 8'h40 || mk_run == 8'h80)
      else $error("marker run of wrong length");
   a_rx_delay: assert property (rx_valid_i |=> rx_valid_o)
      else $error("receive valid not delayed by one");
   a_marker_clear: assert property (rx_valid_i && rx_marker_found_i |=>
      !rx_in_frame_o && rx_sym_o == $past(rx_sym_i))
      else $error("marker symbol altered");
   a_out_frame: assert property (
      rx_valid_o && !rx_in_frame_o |-> rx_sym_o == $past(rx_sym_i))
      else $error("symbol outside frame altered");
   a_reset_quiet: assert property (disable iff (1'b0)
      rst_i |=> !wb_ack_o && !line_valid_o && !rx_valid_o && !tx_ready_o)
      else $error("outputs active after reset");

   c_stall: cover property (line_valid_o && !line_ready_i);
   c_data: cover property (acc && !line_marker_o);
   c_rx_frame: cover property (rx_valid_o && rx_in_frame_o);
   c_turbo_mk: cover property (acc && !line_marker_o && mk_run == 8'h40);
endmodule

bind tfr_top tfr_top_chk #(.SYM_W(SYM_W)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tx_valid_i(tx_valid_i),
   .tx_ready_o(tx_ready_o), .line_bit_o(line_bit_o),
   .line_valid_o(line_valid_o), .line_marker_o(line_marker_o),
   .line_ready_i(line_ready_i), .rx_sym_i(rx_sym_i),
   .rx_valid_i(rx_valid_i), .rx_marker_found_i(rx_marker_found_i),
   .rx_sym_o(rx_sym_o), .rx_valid_o(rx_valid_o),
   .rx_in_frame_o(rx_in_frame_o)
);
`default_nettype wire

// >>> tfr_far_end.sv
`default_nettype none
module tfr_far_end (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Block encoder side
   output logic tx_bit_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   // Convolutional encoder side
   input wire logic line_bit_i,
   input wire logic line_valid_i,
   input wire logic line_marker_i,
   output logic line_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] stall_cnt;
   logic [1:0] got_q[$];

   // Stall one cycle in three so the output hold is exercised
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stall_cnt <= 2'h0;
         line_ready_o <= 1'b0;
      end
      else
      begin
         stall_cnt <= (stall_cnt == 2'h2) ? 2'h0 : stall_cnt + 2'h1;
         line_ready_o <= (stall_cnt != 2'h2);
      end
   end

   // Payload alternates per taken bit, always offered, so a lost
   // XOR or a skipped bit shows on the line
   always @(posedge clk_i)
   begin
      tx_valid_o <= !rst_i;
      if (rst_i)
         tx_bit_o <= 1'b0;
      else if (tx_valid_o && tx_ready_i)
         tx_bit_o <= !tx_bit_o;
      if (!rst_i && line_valid_i && line_ready_o)
         got_q.push_back({line_marker_i, line_bit_i});
   end
endmodule
`default_nettype wire

// >>> tb.sv
`default_nettype none
module tb
   import tfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FLEN = 40;
   localparam int UNIT = 32 + FLEN;
   localparam logic [39:0] SEQ40 = 40'hff480ec09a;
   localparam logic [31:0] EMB = 32'h352ef853;
   localparam logic [63:0] TURBO2 = 64'h034776c7272895b0;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, rx_sym_i, rx_sym_o;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic tx_bit_i, tx_valid_i, tx_ready_o, line_bit_o, line_valid_o;
   logic line_marker_o, line_ready_i, rx_valid_i, rx_marker_found_i;
   logic rx_valid_o, rx_in_frame_o;
   logic [4:0] rx_q[$];
   logic [1:0] ev;
   int n_fail, check_count, n, p;

   tfr_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .tx_bit_i(tx_bit_i), .tx_valid_i(tx_valid_i),
      .tx_ready_o(tx_ready_o), .line_bit_o(line_bit_o),
      .line_valid_o(line_valid_o), .line_marker_o(line_marker_o),
      .line_ready_i(line_ready_i), .rx_sym_i(rx_sym_i),
      .rx_valid_i(rx_valid_i), .rx_marker_found_i(rx_marker_found_i),
      .rx_sym_o(rx_sym_o), .rx_valid_o(rx_valid_o),
      .rx_in_frame_o(rx_in_frame_o));
   tfr_far_end u_far (.clk_i(clk_i), .rst_i(rst_i), .tx_bit_o(tx_bit_i),
      .tx_valid_o(tx_valid_i), .tx_ready_i(tx_ready_o),
      .line_bit_i(line_bit_o), .line_valid_i(line_valid_o),
      .line_marker_i(line_marker_o), .line_ready_o(line_ready_i));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until ack is sampled, then one idle cycle
   task automatic wb_xfer(input logic we, input logic [7:0] adr,
      input logic [31:0] dat, output logic [31:0] rd);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      @(posedge clk_i);
      // Only the watchdog ends a wait for ack
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      rd = wb_dat_o;
      cmp({31'h0, wb_ack_o}, 32'h1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] rd;
      wb_xfer(1'b1, adr, dat, rd);
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb_xfer(1'b0, adr, 32'h0, rd);
      cmp(rd, exp);
   endtask

   // Read with the time-dependent fields masked off
   task automatic rd_mask(input logic [7:0] adr, input logic [31:0] m,
      input logic [31:0] exp);
      logic [31:0] rd;
      wb_xfer(1'b0, adr, 32'h0, rd);
      cmp(rd & m, exp);
   endtask

   // Idle symbols carry the inverse of the last one, not a stale copy
   task automatic rx_put(input logic [3:0] s, input logic mk, input logic v);
      rx_sym_i <= v ? s : ~rx_sym_i;
      rx_valid_i <= v;
      rx_marker_found_i <= mk;
      @(posedge clk_i);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk_i)
      if (rx_valid_o === 1'b1)
         rx_q.push_back({rx_in_frame_o, rx_sym_o});

   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      finish_test;
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial
   begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 44'hfff;
      {rx_sym_i, rx_valid_i, rx_marker_found_i} = 6'h0;
      n_fail = 0;
      check_count = 0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(TFR_REG_CTRL, 32'h0);
      rd_chk(TFR_REG_FLEN, {16'h0, TFR_FLEN_RST});
      wr(8'h40, 32'hffffffff);
      rd_chk(8'h40, 32'h0);
      $display("test reset and hole done");
      wr(TFR_REG_CTRL, 32'h14);
      rd_chk(TFR_REG_CTRL, 32'h10);
      wr(TFR_REG_CTRL, 32'h24);
      rd_chk(TFR_REG_CTRL, 32'h20);
      wr(TFR_REG_CTRL, 32'h34);
      rd_chk(TFR_REG_CTRL, 32'h0);
      wr(TFR_REG_CTRL, 32'h06);
      rd_chk(TFR_REG_CTRL, 32'h06);
      wr(TFR_REG_FLEN, FLEN);
      wr(TFR_REG_CTRL, 32'h07);
      wr(TFR_REG_CTRL, 32'h05);
      rd_chk(TFR_REG_CTRL, 32'h07);
      $display("test control done");
      for (int i = 0; i < 4; i++)
         rx_put(4'h5, i == 3, 1'b1);
      for (int i = 0; i < FLEN; i++)
      begin
         if (i == 5)
            rx_put(4'h0, 1'b0, 1'b0);
         rx_put(4'h3, 1'b0, 1'b1);
      end
      rx_put(4'h3, 1'b0, 1'b1);
      rx_put(4'h3, 1'b0, 1'b1);
      rx_put(4'h0, 1'b0, 1'b0);
      @(posedge clk_i);
      cmp(rx_q.size(), 46);
      for (int i = 0; i < 46; i++)
         cmp(rx_q[i], (i < 4) ? 5'h05 : (i >= 44) ? 5'h03 :
            SEQ40[43-i] ? 5'h1c : 5'h13);
      rd_mask(TFR_REG_STAT, 32'h00ff0003, 32'h00010001);
      $display("test receive done");
      while (u_far.got_q.size() < 2 * UNIT)
         @(posedge clk_i);
      for (int i = 0; i < 2 * UNIT; i++)
      begin
         p = i % UNIT;
         ev = (p < 32) ? {1'b1, EMB[31-p]} : {1'b0, SEQ40[71-p] ^ p[0]};
         cmp(u_far.got_q[i], ev);
      end
      $display("test transmit done");
      // Stop lets the running frame finish before the mode changes
      wr(TFR_REG_CTRL, 32'h00);
      repeat (200) @(posedge clk_i);
      rd_mask(TFR_REG_STAT, 32'h00000001, 32'h0);
      n = u_far.got_q.size();
      wr(TFR_REG_CTRL, 32'h11);
      while (u_far.got_q.size() < n + 64 + FLEN)
         @(posedge clk_i);
      for (int i = 0; i < 64 + FLEN; i++)
      begin
         ev = (i < 64) ? {1'b1, TURBO2[63-i]} : {1'b0, i[0]};
         cmp(u_far.got_q[n + i], ev);
      end
      $display("test turbo transmit done");
      finish_test;
   end
endmodule
`default_nettype wire
